/* File: shared/co_map_pkg.sv */
// Constants for the remote-command object mapper.
// Assumes one clock domain and AHB-Lite register access.
package co_map_pkg;
    // Object dictionary
    localparam logic [15:0] CO_USER_BASE = 16'h2001;
    localparam logic [15:0] OBJ_NOM_VOLT = 16'd121;
    localparam logic [15:0] OBJ_REMOTE = 16'd402;
    localparam logic [15:0] OBJ_SET_V = 16'd500;
    localparam logic [15:0] OBJ_SET_I = 16'd501;
    localparam logic [15:0] OBJ_SET_P = 16'd502;
    localparam logic [15:0] OBJ_STATUS = 16'd505;
    localparam logic [15:0] OBJ_ACT_V = 16'd507;
    localparam logic [15:0] OBJ_ACT_I = 16'd508;
    localparam logic [15:0] OBJ_ACT_P = 16'd509;
    localparam logic [15:0] OBJ_GEN_RUN = 16'd850;
    localparam logic [15:0] OBJ_GEN_U = 16'd851;
    localparam logic [15:0] OBJ_GEN_I = 16'd852;
    localparam logic [15:0] OBJ_GEN_START = 16'd859;
    localparam logic [15:0] OBJ_GEN_END = 16'd860;
    localparam logic [15:0] OBJ_GEN_REP = 16'd861;
    localparam logic [15:0] OBJ_GEN_SUBMIT = 16'd862;
    localparam logic [15:0] OBJ_PT_FIRST = 16'd900;
    localparam logic [15:0] OBJ_PT_LAST = 16'd2468;
    localparam int PT_STRIDE_SH = 4;
    // Values and codes
    localparam logic [15:0] CMD_ON = 16'hff00;
    localparam logic [15:0] CMD_OFF = 16'h0000;
    localparam logic [15:0] SETVAL_FULL = 16'hcccc;
    localparam logic [15:0] SETVAL_RST = 16'h0000;
    localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
    localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
    localparam logic [31:0] ABORT_RANGE = 32'h0609_0030;
    localparam logic [31:0] ABORT_NOOBJ = 32'h0602_0000;
    localparam logic [15:0] APPLIED_MAX = 16'd26214;
    localparam int ST_MASTER = 6;
    localparam int ST_OUT_ON = 7;
    localparam int ST_CURR_REG = 10;
    // Sizes
    localparam int VAL_W = 16;
    localparam int NUM_POINTS = 99;
    localparam int PT_VALS = 8;
    localparam int PT_IDX_W = 7;
    localparam int SUB_W = 8;
    localparam int NUM_SLOTS = 8;
    localparam int USED_SLOTS = 4;
    // AHB register offsets
    localparam logic [7:0] A_INDEX = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_RESULT = 8'h0c;
    localparam logic [7:0] A_RDATA = 8'h10;
    localparam logic [7:0] A_STATE = 8'h14;
    localparam logic [7:0] A_SLOT = 8'h20;
endpackage : co_map_pkg

/* File: design/seq_point_store.sv */
// Sequence point storage: one write port, one registered read port.
// Assumes indexes are range-checked by the caller.
module seq_point_store #(
    parameter int POINTS = 99,
    parameter int VALS = 8,
    parameter int W = 16,
    parameter int IW = 7
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_pt,
    input wire logic [2:0] wr_val,
    input wire logic [W-1:0] wr_data,
    input wire logic [IW-1:0] rd_pt,
    input wire logic [2:0] rd_val,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem_q [POINTS*VALS];
    logic [W-1:0] rd_q;

    genvar g;
    generate
        for (g = 0; g < POINTS*VALS; g++) begin : g_ent
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mem_q[g] <= '0;
                end else if (wr_en && (int'(wr_pt) * VALS + int'(wr_val) == g)) begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // Out-of-range read gives zero
    wire rd_in = int'(rd_pt) < POINTS;
    wire [W-1:0] rd_d = rd_in ? mem_q[int'(rd_pt) * VALS + int'(rd_val)] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd_d;
        end
    end
    assign rd_data = rd_q;
endmodule : seq_point_store

/* File: design/canopen_object_mapper.sv */
// Remote-command front end: cyclic slots, index mapping, set values, generator.
// Assumes unit status and actuals come from logic on hclk; one AHB-Lite master.
// Functional notes
// - Slot one carries status: bit 6 master, 7 output on, 10 constant current.
// - Slots two to four carry actual voltage, current, power; 52428 is nominal.
// - Eight cyclic slots; only slots one to four hold data, rest read zero.
// - Register number is the user index minus 0x2001.
// - 0xFF00 to index 0x2193 enters remote, 0x0000 returns to manual.
// - Set-value writes accepted only while remote control is granted.
// - Set values are linear, 0x0000 is 0 percent, 0xCCCC is 100 percent.
// - Applied output value has 26214 steps, coarser than the code range.
// - Master sends each point's eight values as eight separate messages.
// - Each point value is checked against nominal when it arrives.
// - Point data is loaded only after 0xFF00 to submit object 235F.
// - Point data refused until voltage or current generator selection exists.
// - Up to 99 points, indexes 2385 to 29A5, eight sub-index values each.
// - Generator starts and stops on writes to object 2353.
// - Writing 0x0000 to the chosen selection object leaves the generator.
// - Floating-point objects such as nominal voltage read as IEEE 754 words.
// - Reads are answered whether or not remote control is active.
// - Writes impossible in the present state abort with 0x08000022.
// - Writes with out-of-range values abort with 0x06090030.
module canopen_object_mapper #(
    // IEEE 754 encoding; real value is supplied by integration
    parameter logic [31:0] NOM_VOLT_REAL32 = 32'h0000_0000,
    parameter int POINTS = co_map_pkg::NUM_POINTS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic master_role,
    input wire logic output_on,
    input wire logic constant_current_regulation,
    input wire logic [co_map_pkg::VAL_W-1:0] act_voltage,
    input wire logic [co_map_pkg::VAL_W-1:0] act_current,
    input wire logic [co_map_pkg::VAL_W-1:0] act_power,
    output logic remote_active,
    output logic [14:0] applied_voltage,
    output logic [14:0] applied_current,
    output logic [14:0] applied_power,
    output logic gen_on_voltage,
    output logic gen_on_current,
    output logic gen_loaded,
    output logic gen_running,
    output logic [co_map_pkg::PT_IDX_W-1:0] gen_start_pt,
    output logic [co_map_pkg::PT_IDX_W-1:0] gen_end_pt,
    output logic [15:0] gen_repeats,
    input wire logic [co_map_pkg::PT_IDX_W-1:0] pt_rd_point,
    input wire logic [2:0] pt_rd_val,
    output logic [co_map_pkg::VAL_W-1:0] pt_rd_data
);
    import co_map_pkg::*;

    logic dph_q, wr_q, wait_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q, index_q, data_q, result_q, cmd_rdata_q;
    logic remote_q, sel_u_q, sel_i_q, loaded_q, run_q;
    logic [15:0] set_v_q, set_i_q, set_p_q, rep_q;
    logic [PT_IDX_W-1:0] start_q, end_q;
    logic [31:0] abort_code, cmd_rd_val;

    // Bus address phase
    wire accept = hsel && htrans[1] && hready;
    wire ctrl_wr_acc = accept && hwrite && haddr[7:0] == A_CTRL;
    wire reg_wr = dph_q && wr_q && hreadyout;
    assign hreadyout = !wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Command strobes, one cycle during the stalled CTRL data phase
    wire go_wr = wait_q && hwdata[0];
    wire go_rd = wait_q && !hwdata[0] && hwdata[1];
    wire go = go_wr || go_rd;

    wire [15:0] regnum = index_q[15:0] - CO_USER_BASE;
    wire [SUB_W-1:0] sub = index_q[16 +: SUB_W];
    wire [15:0] wval = data_q[15:0];
    wire v_on = wval == CMD_ON;
    wire v_off = wval == CMD_OFF;
    wire v_sw = v_on || v_off;
    wire v_over = wval > SETVAL_FULL;

    wire hit_remote = regnum == OBJ_REMOTE;
    wire hit_sv = regnum == OBJ_SET_V || regnum == OBJ_SET_I || regnum == OBJ_SET_P;
    wire hit_run = regnum == OBJ_GEN_RUN;
    wire hit_gu = regnum == OBJ_GEN_U;
    wire hit_gi = regnum == OBJ_GEN_I;
    wire hit_se = regnum == OBJ_GEN_START || regnum == OBJ_GEN_END;
    wire hit_rep = regnum == OBJ_GEN_REP;
    wire hit_sub = regnum == OBJ_GEN_SUBMIT;
    wire [15:0] pt_off = regnum - OBJ_PT_FIRST;
    wire hit_pt = regnum >= OBJ_PT_FIRST && regnum <= OBJ_PT_LAST && pt_off[3:0] == 4'h0;
    wire [PT_IDX_W-1:0] pt_num = pt_off[PT_STRIDE_SH +: PT_IDX_W];
    // one value per write, sub-index picks it
    wire pt_bad = int'(pt_num) >= POINTS || sub == '0 || int'(sub) > PT_VALS;
    wire sel_any = sel_u_q || sel_i_q;
    wire se_bad = wval == 16'h0000 || int'(wval) > POINTS;
    wire hit_rd = regnum == OBJ_NOM_VOLT || hit_remote || hit_sv || hit_run || hit_gu
        || hit_gi || hit_se || hit_rep || regnum == OBJ_STATUS
        || regnum == OBJ_ACT_V || regnum == OBJ_ACT_I || regnum == OBJ_ACT_P;

    always_comb begin
        abort_code = ABORT_NONE;
        if (go_wr) begin
            if (hit_remote) begin
                if (!v_sw) abort_code = ABORT_RANGE;
            end else if (!(hit_sv || hit_run || hit_gu || hit_gi || hit_se
                           || hit_rep || hit_sub || hit_pt)) begin
                abort_code = ABORT_NOOBJ;
            end else if (!remote_q) begin
                abort_code = ABORT_STATE;
            end else if (hit_sv) begin
                if (v_over) abort_code = ABORT_RANGE;
            end else if (hit_gu || hit_gi) begin
                if (!v_sw) abort_code = ABORT_RANGE;
                else if (v_on && (hit_gu ? sel_i_q : sel_u_q)) abort_code = ABORT_STATE;
            end else if (hit_run) begin
                if (!v_sw) abort_code = ABORT_RANGE;
                else if (v_on && !(loaded_q && sel_any)) abort_code = ABORT_STATE;
            end else if (hit_se) begin
                if (se_bad) abort_code = ABORT_RANGE;
            end else if (hit_sub) begin
                if (!v_on) abort_code = ABORT_RANGE;
                else if (!sel_any) abort_code = ABORT_STATE;
            end else if (hit_pt) begin
                if (!sel_any) abort_code = ABORT_STATE;
                else if (pt_bad || v_over) abort_code = ABORT_RANGE;
            end
        end else if (go_rd && !hit_rd) begin
            abort_code = ABORT_NOOBJ;
        end
    end
    wire wr_ok = go_wr && abort_code == ABORT_NONE;

    wire [15:0] status_w = 16'(({15'h0, master_role} << ST_MASTER)
        | ({15'h0, output_on} << ST_OUT_ON)
        | ({15'h0, constant_current_regulation} << ST_CURR_REG));
    always_comb begin
        cmd_rd_val = 32'h0;
        // nominal voltage as IEEE 754 word
        if (regnum == OBJ_NOM_VOLT) cmd_rd_val = NOM_VOLT_REAL32;
        else if (hit_remote) cmd_rd_val = {16'h0, remote_q ? CMD_ON : CMD_OFF};
        else if (regnum == OBJ_SET_V) cmd_rd_val = {16'h0, set_v_q};
        else if (regnum == OBJ_SET_I) cmd_rd_val = {16'h0, set_i_q};
        else if (regnum == OBJ_SET_P) cmd_rd_val = {16'h0, set_p_q};
        else if (regnum == OBJ_STATUS) cmd_rd_val = {16'h0, status_w};
        else if (regnum == OBJ_ACT_V) cmd_rd_val = {16'h0, act_voltage};
        else if (regnum == OBJ_ACT_I) cmd_rd_val = {16'h0, act_current};
        else if (regnum == OBJ_ACT_P) cmd_rd_val = {16'h0, act_power};
        else if (hit_run) cmd_rd_val = {16'h0, run_q ? CMD_ON : CMD_OFF};
        else if (hit_gu) cmd_rd_val = {16'h0, sel_u_q ? CMD_ON : CMD_OFF};
        else if (hit_gi) cmd_rd_val = {16'h0, sel_i_q ? CMD_ON : CMD_OFF};
        else if (regnum == OBJ_GEN_START) cmd_rd_val = {25'h0, start_q};
        else if (regnum == OBJ_GEN_END) cmd_rd_val = {25'h0, end_q};
        else if (hit_rep) cmd_rd_val = {16'h0, rep_q};
    end

    // Bus read mux, sampled in the address phase
    wire [7:0] ra = haddr[7:0];
    // slots five to eight stay empty
    wire slot_hit = ra >= A_SLOT && ra < A_SLOT + 8'(4 * NUM_SLOTS) && ra[1:0] == 2'b00;
    wire [2:0] slot_n = 3'(ra[4:2]);
    wire [31:0] slot_val = slot_n == 3'd0 ? {16'h0, status_w}
        : slot_n == 3'd1 ? {16'h0, act_voltage}
        : slot_n == 3'd2 ? {16'h0, act_current}
        : slot_n == 3'd3 ? {16'h0, act_power} : 32'h0;
    wire [31:0] state_w = {27'h0, run_q, loaded_q, sel_i_q, sel_u_q, remote_q};
    wire [31:0] rd_mux = ra == A_INDEX ? index_q : ra == A_DATA ? data_q
        : ra == A_RESULT ? result_q : ra == A_RDATA ? cmd_rdata_q
        : ra == A_STATE ? state_w : slot_hit ? slot_val : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            wait_q <= 1'b0;
            hrdata_q <= 32'h0;
        end else begin
            if (hreadyout) begin
                dph_q <= accept;
                wr_q <= accept && hwrite;
                addr_q <= haddr[7:0];
            end
            // One wait state lets a following read see the result
            wait_q <= ctrl_wr_acc;
            if (accept && !hwrite) hrdata_q <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            index_q <= 32'h0;
            data_q <= 32'h0;
        end else if (reg_wr) begin
            if (addr_q == A_INDEX) index_q <= hwdata;
            if (addr_q == A_DATA) data_q <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= ABORT_NONE;
            cmd_rdata_q <= 32'h0;
        end else if (go) begin
            result_q <= abort_code;
            if (go_rd) cmd_rdata_q <= hit_rd ? cmd_rd_val : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remote_q <= 1'b0;
        end else if (wr_ok && hit_remote) begin
            remote_q <= v_on;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            set_v_q <= SETVAL_RST;
            set_i_q <= SETVAL_RST;
            set_p_q <= SETVAL_RST;
        end else if (wr_ok && hit_sv) begin
            if (regnum == OBJ_SET_V) set_v_q <= wval;
            if (regnum == OBJ_SET_I) set_i_q <= wval;
            if (regnum == OBJ_SET_P) set_p_q <= wval;
        end
    end
    // halve the code to 26214 output steps
    assign applied_voltage = set_v_q[15:1];
    assign applied_current = set_i_q[15:1];
    assign applied_power = set_p_q[15:1];

    // Generator selection, run and load state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_u_q <= 1'b0;
            sel_i_q <= 1'b0;
            run_q <= 1'b0;
            loaded_q <= 1'b0;
        end else if (wr_ok) begin
            if (hit_gu || hit_gi) begin
                if (hit_gu) sel_u_q <= v_on;
                if (hit_gi) sel_i_q <= v_on;
                if (v_off) run_q <= 1'b0;
            end
            if (hit_run) run_q <= v_on;
            if (hit_sub) loaded_q <= 1'b1;
            if (hit_pt) loaded_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q <= '0;
            end_q <= '0;
            rep_q <= 16'h0;
        end else if (wr_ok) begin
            if (regnum == OBJ_GEN_START) start_q <= wval[PT_IDX_W-1:0];
            if (regnum == OBJ_GEN_END) end_q <= wval[PT_IDX_W-1:0];
            if (hit_rep) rep_q <= wval;
        end
    end

    logic [VAL_W-1:0] store_rd;
    // point storage, value index is sub-index minus one
    seq_point_store #(.POINTS(POINTS), .VALS(PT_VALS), .W(VAL_W), .IW(PT_IDX_W)) u_store (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_ok && hit_pt),
        .wr_pt(pt_num),
        .wr_val(3'(sub - 8'd1)),
        .wr_data(wval),
        .rd_pt(pt_rd_point),
        .rd_val(pt_rd_val),
        .rd_data(store_rd)
    );
    // without submit the generator sees zeros
    assign pt_rd_data = loaded_q ? store_rd : '0;

    assign remote_active = remote_q;
    assign gen_on_voltage = sel_u_q;
    assign gen_on_current = sel_i_q;
    assign gen_loaded = loaded_q;
    assign gen_running = run_q;
    assign gen_start_pt = start_q;
    assign gen_end_pt = end_q;
    assign gen_repeats = rep_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_slot_empty;
        accept && !hwrite && slot_hit && slot_n >= 3'(USED_SLOTS) |=> hrdata == 32'h0;
    endproperty
    a_slot_empty: assert property (p_slot_empty) else $error("empty slot not zero");

    property p_status_slot;
        accept && !hwrite && haddr[7:0] == A_SLOT |=>
            hrdata[ST_CURR_REG] == $past(constant_current_regulation)
            && hrdata[ST_MASTER] == $past(master_role) && hrdata[ST_OUT_ON] == $past(output_on);
    endproperty
    a_status_slot: assert property (p_status_slot) else $error("status slot bits wrong");

    property p_act_slot;
        accept && !hwrite && haddr[7:0] == A_SLOT + 8'h04 |=> hrdata[15:0] == $past(act_voltage);
    endproperty
    a_act_slot: assert property (p_act_slot) else $error("voltage slot wrong");

    property p_remote_on;
        go_wr && hit_remote && v_on |=> remote_q && result_q == ABORT_NONE;
    endproperty
    a_remote_on: assert property (p_remote_on) else $error("remote not granted");

    property p_local_refuse;
        go_wr && !remote_q && hit_sv |=> result_q == ABORT_STATE && $stable(set_v_q);
    endproperty
    a_local_refuse: assert property (p_local_refuse) else $error("local write taken");

    property p_over_range;
        go_wr && remote_q && hit_sv && v_over |=> result_q == ABORT_RANGE && $stable(set_i_q);
    endproperty
    a_over_range: assert property (p_over_range) else $error("over range accepted");

    property p_applied_max;
        applied_voltage <= APPLIED_MAX[14:0] && applied_current <= APPLIED_MAX[14:0];
    endproperty
    a_applied_max: assert property (p_applied_max) else $error("applied above range");

    property p_pt_gate;
        go_wr && remote_q && hit_pt && !sel_any |=> result_q == ABORT_STATE;
    endproperty
    a_pt_gate: assert property (p_pt_gate) else $error("point taken without selection");

    property p_submit;
        wr_ok && hit_sub |=> loaded_q ##1 (pt_rd_data == store_rd);
    endproperty
    a_submit: assert property (p_submit) else $error("submit did not load");

    property p_exit;
        wr_ok && (hit_gu || hit_gi) && v_off |=> !run_q && !(sel_u_q && sel_i_q);
    endproperty
    a_exit: assert property (p_exit) else $error("generator not left");
endmodule : canopen_object_mapper

/* File: tb/unit_model.sv */
// Unit-side model: status levels and actual values seen by the mapper.
// Assumes the values stay constant for the whole run, set by continuous assigns.
module unit_model #(
    parameter logic [15:0] VOLT = 16'h263a,
    parameter logic [15:0] CURR = 16'h0c9b,
    parameter logic [15:0] PWR = 16'h0925
) (
    output logic master_role,
    output logic output_on,
    output logic constant_current_regulation,
    output logic [15:0] act_voltage,
    output logic [15:0] act_current,
    output logic [15:0] act_power
);
    timeunit 1ns;
    timeprecision 1ps;
    // All three flags set so every status bit is seen
    assign master_role = 1'b1;
    assign output_on = 1'b1;
    assign constant_current_regulation = 1'b1;
    assign act_voltage = VOLT;
    assign act_current = CURR;
    assign act_power = PWR;
endmodule : unit_model

/* File: tb/testbench.sv */
// Testbench: AHB-Lite master tasks driving object commands into the mapper.
// Assumes one slave on the bus, hready looped back from hreadyout.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import co_map_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [1:0] htrans = 2'h0;
    logic [6:0] rd_pt = 7'h00;
    logic [2:0] rd_val = 3'h0;
    wire hreadyout, hresp, remote, gu, gi, gl, gr, mr, oo, ccr;
    wire [31:0] hrdata;
    wire [14:0] av, ai, ap;
    wire [6:0] gsp, gep;
    wire [15:0] grep, prd, v, i, p;
    int n_errors = 0, comparisons = 0;
    logic [31:0] slot_exp [8] = '{32'h4c0, 32'h263a, 32'h0c9b, 32'h0925, 0, 0, 0, 0};
    always #25 hclk = ~hclk;
    unit_model um_u (.master_role(mr), .output_on(oo), .constant_current_regulation(ccr),
        .act_voltage(v), .act_current(i), .act_power(p));
    canopen_object_mapper #(.NOM_VOLT_REAL32(32'h4379_0000), .POINTS(99)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_role(mr),
        .output_on(oo), .constant_current_regulation(ccr), .act_voltage(v),
        .act_current(i), .act_power(p), .remote_active(remote), .applied_voltage(av),
        .applied_current(ai), .applied_power(ap), .gen_on_voltage(gu), .gen_on_current(gi),
        .gen_loaded(gl), .gen_running(gr), .gen_start_pt(gsp), .gen_end_pt(gep),
        .gen_repeats(grep), .pt_rd_point(rd_pt), .pt_rd_val(rd_val), .pt_rd_data(prd));
    task automatic conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
            n_errors++;
        end
    endtask : chk
    // Ready is sampled at the rising edge, as the slave sees it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic obj(input logic wr, input logic [15:0] rn, input logic [7:0] sub,
        input logic [15:0] val, input logic [31:0] exp, output logic [31:0] rd);
        bus(1'b1, A_INDEX, {8'h00, sub, rn + CO_USER_BASE}, rd);
        bus(1'b1, A_DATA, {16'h0, val}, rd);
        bus(1'b1, A_CTRL, wr ? 32'h1 : 32'h2, rd);
        bus(1'b0, A_RESULT, 32'h0, rd);
        chk("result", exp, rd);
        bus(1'b0, A_RDATA, 32'h0, rd);
    endtask : obj
    initial begin
        #200us;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, A_SLOT + 8'(4 * k), 32'h0, r);
            chk("slot", slot_exp[k], r);
        end
        bus(1'b0, 8'h44, 32'h0, r);
        chk("unmapped", 32'h0, r);
        obj(1'b0, OBJ_ACT_V, 8'h00, 16'h0, ABORT_NONE, r);
        chk("act_v", 32'h263a, r);
        obj(1'b0, OBJ_NOM_VOLT, 8'h00, 16'h0, ABORT_NONE, r);
        chk("nominal", 32'h4379_0000, r);
        obj(1'b1, OBJ_SET_V, 8'h00, 16'h1000, ABORT_STATE, r);
        chk("av_local", 32'h0, {17'h0, av});
        obj(1'b1, OBJ_REMOTE, 8'h00, 16'h1234, ABORT_RANGE, r);
        obj(1'b1, OBJ_REMOTE, 8'h00, CMD_ON, ABORT_NONE, r);
        chk("remote_on", 32'h1, {31'h0, remote});
        obj(1'b1, OBJ_SET_V, 8'h00, SETVAL_FULL, ABORT_NONE, r);
        obj(1'b1, OBJ_SET_V, 8'h00, 16'hcccd, ABORT_RANGE, r);
        chk("av_full", 32'd26214, {17'h0, av});
        obj(1'b1, OBJ_SET_I, 8'h00, 16'h0c0c, ABORT_NONE, r);
        chk("ai", 32'h0606, {17'h0, ai});
        obj(1'b1, OBJ_SET_P, 8'h00, 16'h0002, ABORT_NONE, r);
        chk("ap", 32'h1, {17'h0, ap});
        obj(1'b1, OBJ_PT_FIRST, 8'h01, 16'h0100, ABORT_STATE, r);
        obj(1'b1, OBJ_GEN_U, 8'h00, CMD_ON, ABORT_NONE, r);
        obj(1'b1, OBJ_GEN_I, 8'h00, CMD_ON, ABORT_STATE, r);
        chk("sel", 32'h1, {30'h0, gi, gu});
        obj(1'b1, OBJ_GEN_START, 8'h00, 16'h0000, ABORT_RANGE, r);
        obj(1'b1, OBJ_GEN_START, 8'h00, 16'h0001, ABORT_NONE, r);
        obj(1'b1, OBJ_GEN_END, 8'h00, 16'd100, ABORT_RANGE, r);
        obj(1'b1, OBJ_GEN_END, 8'h00, 16'd99, ABORT_NONE, r);
        obj(1'b1, OBJ_GEN_REP, 8'h00, 16'h0005, ABORT_NONE, r);
        chk("gen_cfg", {7'h01, 7'd99, 16'h5}, {2'h0, gsp, gep, grep});
        for (int s = 1; s <= 8; s++) begin
            obj(1'b1, OBJ_PT_FIRST, 8'(s), 16'h1000 + 16'(s), ABORT_NONE, r);
        end
        obj(1'b1, OBJ_PT_FIRST, 8'h00, 16'h0001, ABORT_RANGE, r);
        obj(1'b1, OBJ_PT_LAST, 8'h08, 16'hcccd, ABORT_RANGE, r);
        obj(1'b1, OBJ_PT_LAST, 8'h08, SETVAL_FULL, ABORT_NONE, r);
        obj(1'b1, OBJ_GEN_RUN, 8'h00, CMD_ON, ABORT_STATE, r);
        chk("not_loaded", 32'h0, {31'h0, gl});
        obj(1'b1, OBJ_GEN_SUBMIT, 8'h00, 16'h0001, ABORT_RANGE, r);
        obj(1'b1, OBJ_GEN_SUBMIT, 8'h00, CMD_ON, ABORT_NONE, r);
        @(posedge hclk);
        rd_val <= 3'h7;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("pt_data", 32'h1008, {16'h0, prd});
        @(posedge hclk);
        rd_pt <= 7'd98;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("pt_last", {16'h0, SETVAL_FULL}, {16'h0, prd});
        obj(1'b1, OBJ_GEN_RUN, 8'h00, CMD_ON, ABORT_NONE, r);
        chk("run", 32'h3, {30'h0, gl, gr});
        obj(1'b1, OBJ_GEN_RUN, 8'h00, CMD_OFF, ABORT_NONE, r);
        obj(1'b1, OBJ_GEN_RUN, 8'h00, CMD_ON, ABORT_NONE, r);
        obj(1'b1, OBJ_GEN_U, 8'h00, CMD_OFF, ABORT_NONE, r);
        chk("exit", 32'h0, {30'h0, gu, gr});
        obj(1'b1, OBJ_GEN_SUBMIT, 8'h00, CMD_ON, ABORT_STATE, r);
        obj(1'b1, OBJ_REMOTE, 8'h00, CMD_OFF, ABORT_NONE, r);
        chk("remote_off", 32'h0, {31'h0, remote});
        obj(1'b0, OBJ_SET_V, 8'h00, 16'h0, ABORT_NONE, r);
        chk("set_v_read", {16'h0, SETVAL_FULL}, r);
        obj(1'b0, OBJ_GEN_SUBMIT, 8'h00, 16'h0, ABORT_NOOBJ, r);
        chk("noobj_data", 32'h0, r);
        bus(1'b0, A_STATE, 32'h0, r);
        chk("state", 32'h8, r);
        chk("hresp", 32'h0, {31'h0, hresp});
        conclude();
    end
endmodule : testbench
